/* File: bench/flag_access_gate_chk.sv */
`timescale 1ns/1ps
module flag_access_gate_chk #(
  parameter logic [31:0] CAP_VALUE = 32'h0000_0000
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        cmdBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic        acc;
  logic        rdAcc;
  logic        goWr;
  logic        hashOff;
  logic [2:0]  loc;
  logic [11:0] off;
  assign acc = psel && penable;
  assign rdAcc = acc && !pwrite;
  assign loc = paddr[14:12];
  assign off = paddr[11:0];
  assign hashOff = off inside {12'h030, 12'h034, 12'h038};
  assign goWr = acc && pwrite && off == 12'h018 && pwdata[5];
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("ready missing");
  property p_err_idle; !acc |-> !pslverr; endproperty
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  property p_wr_zero; acc && pwrite |-> prdata == 32'h0000_0000; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write data not zero");
  property p_hash_ff;
    rdAcc && loc == 3'h4 && hashOff |-> prdata == 32'h0000_00FF;
  endproperty
  a_hash_ff: assert property (p_hash_ff) else $error("hash read");
  property p_loc4_err; acc && loc == 3'h4 && !hashOff |-> pslverr; endproperty
  a_loc4_err: assert property (p_loc4_err) else $error("loc4 reach");
  property p_cap;
    rdAcc && loc <= 3'h3 && off == 12'h014 |-> prdata == CAP_VALUE;
  endproperty
  a_cap: assert property (p_cap) else $error("capability value");
  property p_acc_valid; rdAcc && loc <= 3'h3 && off == 12'h000 |-> prdata[7];
  endproperty
  a_acc_valid: assert property (p_acc_valid) else $error("access read");
  property p_busy_src; $rose(cmdBusy) |-> $past(goWr) || $past(goWr, 2);
  endproperty
  a_busy_src: assert property (p_busy_src) else $error("busy cause");
  property p_irq_fall; $fell(irq) |-> $past(acc); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
endmodule

bind flag_access_gate flag_access_gate_chk #(.CAP_VALUE(CAP_VALUE)) chk (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .cmdBusy(cmdBusy)
);

/* File: bench/flag_access_gate_test.sv */
`timescale 1ns/1ps
module flag_access_gate_test;
  localparam logic [31:0] CAPV = 32'h0000_0A5C;
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        cmdBusy;
  logic        tmo;
  logic [31:0] b1;
  logic [31:0] b2;
  logic [31:0] ev;
  logic [31:0] em;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  integer      seed = 32'hDF5FB037;
  int          fail_count = 0;
  int          tests_run = 0;
  int          n;

  flag_access_gate #(.EXEC_CYCLES(20), .CAP_VALUE(CAPV)) uut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .cmdBusy(cmdBusy)
  );
  flag_host_model host (
    .clk(clk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tmo(tmo)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic bad(input logic [31:0] g, input logic [31:0] e);
    fail_count++;
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic chk(input logic a, input logic e);
    tests_run++;
    if (a !== e)
      bad({31'h0, a}, {31'h0, e});
  endtask
  task automatic rd(input logic [2:0] l, input logic [11:0] o,
                    input logic [31:0] v,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    expQ.push_back(v & m);
    mskQ.push_back(m);
    host.xfer(1'b0, l, o, 32'h0000_0000);
  endtask
  task automatic wr(input logic [2:0] l, input logic [11:0] o,
                    input logic [31:0] d);
    host.xfer(1'b1, l, o, d);
  endtask
  task automatic idle(input int k);
    host.rel();
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Each read answer is taken at its access edge against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      ev = expQ.pop_front();
      em = mskQ.pop_front();
      tests_run++;
      if ((prdata & em) !== ev)
        bad(prdata, ev);
    end
  end

  always @(posedge tmo) begin
    fail_count++;
    close_out();
  end

  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(3'h0, 12'h018, 32'hFF);
    rd(3'h1, 12'h024, 32'hFF);
    rd(3'h2, 12'h044, 32'hFF);
    rd(3'h0, 12'h000, 32'h80);
    rd(3'h0, 12'h100, 32'h00);
    wr(3'h2, 12'h000, 32'h02);
    rd(3'h1, 12'h018, 32'hFF);
    rd(3'h2, 12'h000, 32'hA0);
    $display("end ownership");
    b1 = $random(seed);
    b2 = $random(seed);
    wr(3'h0, 12'h040, 32'h01);
    rd(3'h3, 12'h040, 32'h01);
    wr(3'h2, 12'h024, b1);
    wr(3'h2, 12'h024, b2);
    wr(3'h1, 12'h024, ~b2);
    rd(3'h2, 12'h024, {24'h0, b2[7:0]});
    rd(3'h0, 12'h024, 32'hFF);
    rd(3'h2, 12'h044, {8'h0, b1[7:0]} + {8'h0, b2[7:0]});
    rd(3'h1, 12'h044, 32'hFF);
    $display("end data");
    wr(3'h2, 12'h00C, b1);
    wr(3'h1, 12'h00C, b2);
    rd(3'h0, 12'h00C, {28'h0, b1[3:0]});
    wr(3'h2, 12'h014, b2);
    rd(3'h1, 12'h014, CAPV);
    wr(3'h2, 12'hF00, 32'h5A);
    wr(3'h0, 12'hF00, 32'h33);
    rd(3'h1, 12'hF00, 32'h5A);
    rd(3'h2, 12'h060, 32'h02);
    wr(3'h2, 12'h064, 32'h02);
    wr(3'h0, 12'h00C, 32'h01);
    idle(1);
    chk(irq, 1'b1);
    @(posedge clk);
    rd(3'h2, 12'h060, 32'h02);
    wr(3'h2, 12'h064, 32'h00);
    wr(3'h1, 12'h018, 32'h20);
    idle(1);
    chk(irq, 1'b0);
    chk(cmdBusy, 1'b0);
    @(posedge clk);
    rd(3'h2, 12'h060, 32'h02);
    $display("end interrupt");
    wr(3'h2, 12'h018, 32'h20);
    wr(3'h3, 12'h000, 32'h02);
    idle(0);
    chk(cmdBusy, 1'b1);
    @(posedge clk);
    wr(3'h2, 12'h000, 32'h20);
    idle(2);
    chk(cmdBusy, 1'b0);
    @(posedge clk);
    rd(3'h3, 12'h060, 32'h01, 32'h01);
    wr(3'h3, 12'h018, 32'h20);
    idle(1);
    chk(cmdBusy, 1'b1);
    n = 0;
    while (cmdBusy !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(n < 60, 1'b1);
    if (n == 60)
      close_out();
    @(posedge clk);
    rd(3'h3, 12'h018, 32'h10, 32'h18);
    wr(3'h0, 12'h010, 32'h01);
    rd(3'h0, 12'h010, 32'h01, 32'h01);
    wr(3'h3, 12'h010, 32'h01);
    rd(3'h1, 12'h010, 32'h00, 32'h01);
    $display("end command");
    wr(3'h3, 12'h000, 32'h20);
    idle(1);
    @(posedge clk);
    wr(3'h4, 12'h030, 32'h00);
    wr(3'h1, 12'h000, 32'h02);
    rd(3'h1, 12'h000, 32'h82);
    rd(3'h4, 12'h034, 32'hFF);
    rd(3'h4, 12'h018, 32'h00);
    wr(3'h4, 12'h034, b1);
    wr(3'h4, 12'h038, 32'h00);
    idle(2);
    @(posedge clk);
    rd(3'h1, 12'h000, 32'hA0);
    idle(1);
    $display("end hash");
    close_out();
  end
endmodule

/* File: bench/flag_host_model.sv */
`timescale 1ns/1ps
module flag_host_model (
  input  wire logic        clk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [15:0]      paddr,
  output logic [31:0]      pwdata,
  output logic             tmo
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    tmo = 1'b0;
  end
  // Call just after a rising edge; psel stays up for a back-to-back setup
  task automatic xfer(input logic w, input logic [2:0] l,
                      input logic [11:0] o, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, l, o};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    tmo <= (k >= 50);
  endtask
  // Released lines show inverted junk so stale values cannot pass
  task automatic rel();
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~pwrite;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    @(posedge clk);
  endtask
endmodule

/* File: rtl/flag_access_gate.sv */
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "flag_map.svh"
module flag_access_gate #(
  parameter int unsigned EXEC_CYCLES = `FLAG_EXEC_CYCLES,
  parameter logic [31:0] CAP_VALUE   = `FLAG_CAP_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             cmdBusy
);
  flag_pkg::flag_gate_type q;
  flag_pkg::flag_gate_type n;

  flag_pkg::flag_loc_type loc;
  logic [11:0]            off;
  logic                   setup;
  logic                   wr;
  logic                   rd;
  logic                   stdLoc;
  logic                   hashLoc;
  logic                   isOwner;
  logic                   noOwner;
  logic                   inCfg;
  logic [31:0]            rdVal;
  logic                   rdHit;
  logic                   byteWr;
  logic                   goWr;
  logic                   readyWr;
  logic                   abort;
  logic                   engBusy;
  logic                   engAvail;
  logic                   engDone;
  logic [15:0]            engCsum;
  logic [7:0]             engByte;
  logic [7:0]             wb;
  logic                   ignored;
  logic                   granted;

  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign loc     = paddr[`FLAG_LOC_MSB:`FLAG_LOC_LSB];
  assign off     = paddr[`FLAG_OFF_MSB:0];
  assign wb      = pwdata[7:0];
  assign stdLoc  = (loc <= `FLAG_LOC_LAST_STD);
  assign hashLoc = (loc == `FLAG_LOC_HASH);
  assign isOwner = (q.owner == loc);
  assign noOwner = (q.owner == `FLAG_LOC_NONE);
  assign inCfg   = (off[11:8] == `FLAG_CFG_HI_NIB);

  // Read mux, evaluated in the setup cycle so prdata is a flop
  always_comb begin
    rdVal = `FLAG_RD_ZERO;
    rdHit = 1'b1;
    if (stdLoc) begin
      if (inCfg) begin
        if (off == `FLAG_OFF_CONFIG) begin
          rdVal = {24'h0, q.cfgByte};
        end
      end else begin
        case (off)
          `FLAG_OFF_ACCESS: begin
            rdVal[`FLAG_ACC_VALID]  = 1'b1;
            rdVal[`FLAG_ACC_ACTIVE] = isOwner;
            rdVal[`FLAG_ACC_REQ]    = q.pending[loc[1:0]];
          end
          `FLAG_OFF_IRQ_EN:   rdVal = {24'h0, q.irqEnable};
          `FLAG_OFF_IRQ_VEC:  rdVal = {28'h0, q.irqVector};
          `FLAG_OFF_IRQ_STS:  rdVal = {24'h0, q.irqStatus};
          `FLAG_OFF_CAP:      rdVal = CAP_VALUE;
          `FLAG_OFF_STATUS: begin
            if (isOwner) begin
              rdVal[`FLAG_STS_VALID] = 1'b1;
              rdVal[`FLAG_STS_READY] = ~engBusy & ~engAvail;
              rdVal[`FLAG_STS_AVAIL] = engAvail;
              rdVal[`FLAG_STS_BUSY]  = engBusy;
            end else begin
              rdVal = `FLAG_RD_BLOCKED;
            end
          end
          `FLAG_OFF_FIFO: begin
            rdVal = isOwner ? {24'h0, engByte} : `FLAG_RD_BLOCKED;
          end
          `FLAG_OFF_CSUM: begin
            rdVal = isOwner ? {16'h0, engCsum} : `FLAG_RD_BLOCKED;
          end
          `FLAG_OFF_CSUM_EN:  rdVal = {31'h0, q.csumEn};
          `FLAG_OFF_EVT_STS:  rdVal = {29'h0, q.evtStatus};
          `FLAG_OFF_EVT_MASK: rdVal = {29'h0, q.evtMask};
          default:            rdHit = 1'b0;
        endcase
      end
    end else if (hashLoc) begin
      case (off)
        `FLAG_OFF_HASH_BEGIN,
        `FLAG_OFF_HASH_DATA,
        `FLAG_OFF_HASH_END: rdVal = `FLAG_RD_BLOCKED;
        default:            rdHit = 1'b0;
      endcase
    end else begin
      rdHit = 1'b0;
    end
  end

  always_comb begin
    n       = q;
    byteWr  = 1'b0;
    goWr    = 1'b0;
    readyWr = 1'b0;
    ignored = 1'b0;
    granted = 1'b0;

    if (setup) begin
      n.prdata = pwrite ? `FLAG_RD_ZERO : rdVal;
      n.slverr = ~rdHit;
    end

    // Only bits that were actually reported are cleared; later sets survive
    if (rd && stdLoc && off == `FLAG_OFF_EVT_STS) begin
      n.evtStatus = q.evtStatus & ~q.prdata[2:0];
    end

    if (wr && stdLoc && rdHit) begin
      if (inCfg) begin
        if (isOwner && off == `FLAG_OFF_CONFIG) begin
          n.cfgByte = wb;
        end else if (!isOwner) begin
          ignored = 1'b1;
        end
      end else begin
        case (off)
          `FLAG_OFF_ACCESS: begin
            if (wb[`FLAG_ACC_REQ] && !isOwner) begin
              n.pending[loc[1:0]] = 1'b1;
            end
            if (wb[`FLAG_ACC_RELINQ]) begin
              if (isOwner) begin
                n.owner = `FLAG_LOC_NONE;
              end
              n.pending[loc[1:0]] = 1'b0;
            end
          end
          `FLAG_OFF_IRQ_EN: begin
            if (isOwner) n.irqEnable = wb;
            else ignored = 1'b1;
          end
          `FLAG_OFF_IRQ_VEC: begin
            if (isOwner) n.irqVector = wb[3:0];
            else ignored = 1'b1;
          end
          `FLAG_OFF_IRQ_STS: begin
            if (isOwner) n.irqStatus = q.irqStatus & ~wb;
            else ignored = 1'b1;
          end
          `FLAG_OFF_STATUS: begin
            if (isOwner) begin
              goWr    = wb[`FLAG_STS_GO];
              readyWr = wb[`FLAG_STS_READY];
            end else begin
              ignored = 1'b1;
            end
          end
          `FLAG_OFF_FIFO: begin
            if (isOwner) byteWr = 1'b1;
            else ignored = 1'b1;
          end
          `FLAG_OFF_CSUM_EN:  n.csumEn = wb[0];
          `FLAG_OFF_EVT_MASK: n.evtMask = wb[2:0];
          default: begin
          end
        endcase
      end
    end

    if (wr && hashLoc) begin
      case (off)
        `FLAG_OFF_HASH_BEGIN: begin
          if (noOwner) begin
            n.owner = `FLAG_LOC_HASH;
            granted = 1'b1;
          end else begin
            ignored = 1'b1;
          end
        end
        `FLAG_OFF_HASH_DATA: begin
          if (isOwner) byteWr = 1'b1;
          else ignored = 1'b1;
        end
        `FLAG_OFF_HASH_END: begin
          if (isOwner) begin
            n.owner = `FLAG_LOC_NONE;
            n.evtStatus[`FLAG_EVT_HASH_DONE] = 1'b1;
          end else begin
            ignored = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Free interface goes to the highest pending locality
    if (noOwner && !granted) begin
      for (int i = 0; i < 4; i++) begin
        if (q.pending[i]) begin
          n.owner = flag_pkg::flag_loc_type'(i);
        end
      end
      if (n.owner != `FLAG_LOC_NONE) begin
        n.pending[n.owner[1:0]] = 1'b0;
      end
    end

    abort = engBusy && (n.owner != q.owner);

    if (n.owner != q.owner) begin
      n.irqStatus[`FLAG_IRQ_LOC_CHG] = 1'b1;
    end
    if (engDone) begin
      n.irqStatus[`FLAG_IRQ_AVAIL] = 1'b1;
    end
    if (abort) begin
      n.evtStatus[`FLAG_EVT_ABORT] = 1'b1;
    end
    if (ignored) begin
      n.evtStatus[`FLAG_EVT_IGNORED] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q           <= '0;
      q.owner     <= `FLAG_LOC_NONE;
      q.irqEnable <= `FLAG_RST_BYTE;
      q.evtStatus <= `FLAG_RST_EVT;
      q.evtMask   <= `FLAG_RST_EVT;
    end else begin
      q <= n;
    end
  end

  flag_cmd_engine #(
    .EXEC_CYCLES (EXEC_CYCLES)
  ) u_engine (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .byteWr    (byteWr),
    .byteIn    (wb),
    .csumEn    (q.csumEn),
    .go        (goWr),
    .ready     (readyWr),
    .abort     (abort),
    .busy      (engBusy),
    .dataAvail (engAvail),
    .done      (engDone),
    .csum      (engCsum),
    .rspByte   (engByte)
  );

  assign prdata  = q.prdata;
  assign pready  = 1'b1;
  assign pslverr = q.slverr & psel & penable;
  assign cmdBusy = engBusy;
  assign irq     = (|(q.evtStatus & q.evtMask))
                 | (q.irqEnable[`FLAG_IRQ_GLOBAL]
                    & (|(q.irqStatus[6:0] & q.irqEnable[6:0])));
endmodule

/* File: rtl/flag_cmd_engine.sv */
`timescale 1ns/1ps
`include "flag_map.svh"
module flag_cmd_engine #(
  parameter int unsigned EXEC_CYCLES = `FLAG_EXEC_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        byteWr,
  input  wire logic [7:0]  byteIn,
  input  wire logic        csumEn,
  input  wire logic        go,
  input  wire logic        ready,
  input  wire logic        abort,
  output logic             busy,
  output logic             dataAvail,
  output logic             done,
  output logic [15:0]      csum,
  output logic [7:0]       rspByte
);
  flag_pkg::flag_eng_type q;
  flag_pkg::flag_eng_type n;

  always_comb begin
    n      = q;
    n.done = 1'b0;
    case (q.state)
      flag_pkg::FLAG_ENG_IDLE: begin
        if (byteWr) begin
          n.lastByte = byteIn;
          if (csumEn) begin
            n.csum = q.csum + {8'h00, byteIn};
          end
        end
        if (ready) begin
          n.csum = 16'h0000;
        end
        if (go) begin
          n.state = flag_pkg::FLAG_ENG_EXEC;
          n.cnt   = 16'(EXEC_CYCLES - 1);
        end
      end
      flag_pkg::FLAG_ENG_EXEC: begin
        if (q.cnt == 16'h0000) begin
          n.state     = flag_pkg::FLAG_ENG_DONE;
          n.dataAvail = 1'b1;
          n.done      = 1'b1;
        end else begin
          n.cnt = q.cnt - 16'h0001;
        end
      end
      flag_pkg::FLAG_ENG_DONE: begin
        if (ready) begin
          n.state     = flag_pkg::FLAG_ENG_IDLE;
          n.dataAvail = 1'b0;
          n.csum      = 16'h0000;
        end
      end
      default: begin
        n.state = flag_pkg::FLAG_ENG_IDLE;
      end
    endcase
    // Abort beats completion in the same cycle
    if (abort && q.state == flag_pkg::FLAG_ENG_EXEC) begin
      n.state = flag_pkg::FLAG_ENG_IDLE;
      n.done  = 1'b0;
      n.dataAvail = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign busy      = (q.state == flag_pkg::FLAG_ENG_EXEC);
  assign dataAvail = q.dataAvail;
  assign done      = q.done;
  assign csum      = q.csum;
  assign rspByte   = q.lastByte;
endmodule

/* File: rtl/flag_map.svh */
`ifndef FLAG_MAP_SVH
`define FLAG_MAP_SVH

// Window decode: locality in paddr[14:12], register offset in paddr[11:0]
`define FLAG_LOC_MSB        14
`define FLAG_LOC_LSB        12
`define FLAG_OFF_MSB        11

// Register offsets inside each locality window
`define FLAG_OFF_ACCESS     12'h000
`define FLAG_OFF_IRQ_EN     12'h008
`define FLAG_OFF_IRQ_VEC    12'h00C
`define FLAG_OFF_IRQ_STS    12'h010
`define FLAG_OFF_CAP        12'h014
`define FLAG_OFF_STATUS     12'h018
`define FLAG_OFF_FIFO       12'h024
`define FLAG_OFF_HASH_BEGIN 12'h030
`define FLAG_OFF_HASH_DATA  12'h034
`define FLAG_OFF_HASH_END   12'h038
`define FLAG_OFF_CSUM_EN    12'h040
`define FLAG_OFF_CSUM       12'h044
`define FLAG_OFF_EVT_STS    12'h060
`define FLAG_OFF_EVT_MASK   12'h064
`define FLAG_OFF_CONFIG     12'hF00
`define FLAG_CFG_HI_NIB     4'hF

// Locality codes
`define FLAG_LOC_NONE       3'h7
`define FLAG_LOC_HASH       3'h4
`define FLAG_LOC_LAST_STD   3'h3

// Locality access register fields
`define FLAG_ACC_VALID      7
`define FLAG_ACC_ACTIVE     5
`define FLAG_ACC_RELINQ     5
`define FLAG_ACC_REQ        1

// Interface status register fields
`define FLAG_STS_VALID      7
`define FLAG_STS_READY      6
`define FLAG_STS_GO         5
`define FLAG_STS_AVAIL      4
`define FLAG_STS_BUSY       3

// Event status bits (read clears)
`define FLAG_EVT_ABORT      0
`define FLAG_EVT_IGNORED    1
`define FLAG_EVT_HASH_DONE  2

// Interrupt status bits (owner write-1 clears); FLAG_IRQ_GLOBAL is the master enable bit of the enable register
`define FLAG_IRQ_AVAIL      0
`define FLAG_IRQ_LOC_CHG    2
`define FLAG_IRQ_GLOBAL     7

// Read answers and reset values
`define FLAG_RD_BLOCKED     32'h0000_00FF
`define FLAG_RD_ZERO        32'h0000_0000
`define FLAG_CAP_DEFAULT    32'h0000_0000
`define FLAG_RST_BYTE       8'h00
`define FLAG_RST_EVT        3'h0

// Command execution time
`define FLAG_CLK_PERIOD_NS  50
`define FLAG_EXEC_TIME_NS   2000
`define FLAG_EXEC_CYCLES    ((`FLAG_EXEC_TIME_NS + `FLAG_CLK_PERIOD_NS - 1) \
                             / `FLAG_CLK_PERIOD_NS)
`endif

/* File: rtl/flag_pkg.sv */
package flag_pkg;

  typedef logic [2:0] flag_loc_type;

  typedef enum logic [1:0] {
    FLAG_ENG_IDLE = 2'h0,
    FLAG_ENG_EXEC = 2'h1,
    FLAG_ENG_DONE = 2'h3
  } flag_eng_state_type;

  typedef struct packed {
    flag_eng_state_type state;
    logic [15:0]        cnt;
    logic [15:0]        csum;
    logic [7:0]         lastByte;
    logic               dataAvail;
    logic               done;
  } flag_eng_type;

  typedef struct packed {
    flag_loc_type owner;
    logic [3:0]   pending;
    logic [7:0]   irqEnable;
    logic [3:0]   irqVector;
    logic [7:0]   irqStatus;
    logic [7:0]   cfgByte;
    logic         csumEn;
    logic [2:0]   evtStatus;
    logic [2:0]   evtMask;
    logic [31:0]  prdata;
    logic         slverr;
  } flag_gate_type;

endpackage
